/* common/tec_pkg.sv */
package tec_pkg;

   // ----------------------------------------------------------------
   // bus geometry and answers
   // ----------------------------------------------------------------
   localparam int unsigned TEC_ADDR_W = 9;
   localparam logic [1:0] TEC_RESP_OKAY = 2'h0;
   localparam logic [1:0] TEC_RESP_SLVERR = 2'h2;

   // ----------------------------------------------------------------
   // register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [6:0] TEC_IDX_COUNTER_CONFIG = 7'h41;
   localparam logic [6:0] TEC_IDX_LINE_HIGH = 7'h42;
   localparam logic [6:0] TEC_IDX_LINE_LOW = 7'h43;
   localparam logic [6:0] TEC_IDX_PATH_HIGH = 7'h44;
   localparam logic [6:0] TEC_IDX_PATH_LOW = 7'h45;
   localparam logic [6:0] TEC_IDX_SYNC_HIGH = 7'h46;
   localparam logic [6:0] TEC_IDX_SYNC_LOW = 7'h47;
   localparam logic [6:0] TEC_IDX_LINE_MODE = 7'h50;

   // ----------------------------------------------------------------
   // counter_config fields
   // ----------------------------------------------------------------
   localparam int unsigned TEC_CFG_W = 7;
   localparam logic [TEC_CFG_W-1:0] TEC_CFG_RESET = 7'h00;
   localparam int unsigned TEC_CFG_EXCESS_ZERO = 0;
   localparam int unsigned TEC_CFG_SYNC_FUNC = 1;
   localparam int unsigned TEC_CFG_FS_REPORT = 2;
   localparam int unsigned TEC_CFG_E1_VIOL = 3;
   localparam int unsigned TEC_CFG_ACCUM_MODE = 4;
   localparam int unsigned TEC_CFG_INTERVAL = 5;
   localparam int unsigned TEC_CFG_MANUAL = 6;

   // ----------------------------------------------------------------
   // line_mode fields
   // ----------------------------------------------------------------
   localparam int unsigned TEC_MODE_W = 3;
   localparam logic [TEC_MODE_W-1:0] TEC_MODE_RESET = 3'h0;
   localparam int unsigned TEC_MODE_E1 = 0;
   localparam int unsigned TEC_MODE_ESF = 1;
   localparam int unsigned TEC_MODE_ZERO_SUBST = 2;

   // ----------------------------------------------------------------
   // counting constants
   // ----------------------------------------------------------------
   localparam int unsigned TEC_CNT_W = 16;
   localparam logic [15:0] TEC_COUNT_MAX = 16'hFFFF;
   localparam logic [15:0] TEC_COUNT_ZERO = 16'h0000;
   localparam int unsigned TEC_NUM_CNT = 3;
   localparam int unsigned TEC_CNT_LINE = 0;
   localparam int unsigned TEC_CNT_PATH = 1;
   localparam int unsigned TEC_CNT_SYNC = 2;
   localparam logic [4:0] TEC_ZEROS_PLAIN = 5'h10;
   localparam logic [4:0] TEC_ZEROS_SUBST = 5'h08;
   localparam logic [15:0] TEC_T1_SHORT_FRAMES = 16'h014D;
   localparam logic [15:0] TEC_E1_SHORT_FRAMES = 16'h01F4;
   localparam int unsigned TEC_FRAMES_PER_SECOND = 8000;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic awvalid;
      logic [TEC_ADDR_W-1:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [TEC_ADDR_W-1:0] araddr;
      logic rready;
   } tec_axi_req_s;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } tec_axi_rsp_s;

   // receive framer events, same clock, strobes one cycle wide
   typedef struct packed {
      logic bit_strobe;
      logic mark_pos;
      logic mark_neg;
      logic subst_code;
      logic frame_start;
      logic multiframe_start;
      logic crc_error;
      logic ft_error;
      logic fs_error;
      logic fps_error;
      logic fas_error;
      logic receive_sync_lost;
      logic fas_sync_lost;
      logic crc4_sync_lost;
      logic fas_search;
   } tec_rx_s;

endpackage

/* core/tec_sat_counter.sv */
`timescale 1ns/100ps
module tec_sat_counter (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic inc,
   input wire logic clear,
   output logic [tec_pkg::TEC_CNT_W-1:0] count
);
   import tec_pkg::*;

   typedef struct packed {
      logic [TEC_CNT_W-1:0] count;
   } tec_sat_state_s;

   tec_sat_state_s s_q;
   tec_sat_state_s s_d;

   // ----------------------------------------------------------------
   // saturating count, event in the clearing cycle starts new period
   // ----------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      if (clear) begin
         s_d.count = inc ? TEC_COUNT_ZERO + 16'h0001 : TEC_COUNT_ZERO;
      end else if (inc && s_q.count != TEC_COUNT_MAX) begin
         s_d.count = s_q.count + 16'h0001;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign count = s_q.count;

endmodule // tec_sat_counter

/* core/tec_error_counters.sv */
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/100ps
// Summary of operation
// - T1 line counter counts bipolar violations, optionally excess zeros.
// - T1 line counter always runs, even while receive sync is lost.
// - excess zeros are 16-zero runs, or 8-zero runs with substitution.
// - E1 violation is same-polarity marks; HDB3 codewords excluded.
// - E1 select bit picks bipolar violations (0) or code violations (1).
// - E1 line counter counts regardless of any sync loss.
// - line counter saturates at 65535, never wraps.
// - line count high byte at 42h, low byte at 43h.
// - T1 ESF path counter counts CRC6 errors, Fs option ignored.
// - T1 D4 path counter counts Ft errors, plus Fs when enabled.
// - T1 path counter halts while receive sync is lost.
// - E1 path counter counts CRC4 errors, halted on FAS/CRC4 loss.
// - path count high byte at 44h, low byte at 45h.
// - T1 multiframe mode counts unsynced multiframes, only while receive sync is lost.
// - T1 F-bit mode counts Ft or FPS errors, halted on sync loss.
// - E1 sync counter counts FAS word errors, halted on sync loss.
// - E1 FAS errors ignored while searching for alignment.
// - sync loss count high byte at 46h, low byte at 47h.
// - outside accumulation mode, counts latch and clear each second, or every 333/500 frames.
// - in accumulation mode only, manual bit rising edge latches and clears on next clock.
// - every counter stops at its maximum value.
module tec_error_counters #(
   parameter int unsigned FRAMES_PER_SECOND = tec_pkg::TEC_FRAMES_PER_SECOND
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire tec_pkg::tec_axi_req_s axi_req,
   output tec_pkg::tec_axi_rsp_s axi_rsp,
   input wire tec_pkg::tec_rx_s rx,
   output logic counts_updated
);
   import tec_pkg::*;

   localparam logic [15:0] SECOND_FRAMES = 16'(FRAMES_PER_SECOND);

   typedef struct packed {
      tec_axi_rsp_s rsp;
      logic [6:0] waddr_idx;
      logic [7:0] wbyte;
      logic wlane0;
      logic [TEC_CFG_W-1:0] cfg;
      logic [TEC_MODE_W-1:0] mode;
      logic manual_prev;
      logic update;
      logic [15:0] frame_cnt;
      logic mark_seen;
      logic last_pol;
      logic bpv_seen;
      logic last_bpv_pol;
      logic [4:0] zero_run;
      logic [TEC_NUM_CNT-1:0][TEC_CNT_W-1:0] snap;
   } tec_top_state_s;

   tec_top_state_s s_q;
   tec_top_state_s s_d;

   logic [TEC_NUM_CNT-1:0] evt;
   logic [TEC_NUM_CNT-1:0][TEC_CNT_W-1:0] cnt;
   logic update_now;
   logic [31:0] rd_data;
   logic [1:0] rd_resp;

   // ----------------------------------------------------------------
   // counters
   // ----------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < TEC_NUM_CNT; gi++) begin : g_cnt
         tec_sat_counter u_cnt (
            .clock(clock),
            .rst_b(rst_b),
            .inc(evt[gi]),
            .clear(update_now),
            .count(cnt[gi])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // read decode
   // ----------------------------------------------------------------
   always_comb begin
      rd_data = 32'h0000_0000;
      rd_resp = TEC_RESP_OKAY;
      case (axi_req.araddr[TEC_ADDR_W-1:2])
         TEC_IDX_COUNTER_CONFIG: rd_data[TEC_CFG_W-1:0] = s_q.cfg;
         TEC_IDX_LINE_MODE: rd_data[TEC_MODE_W-1:0] = s_q.mode;
         TEC_IDX_LINE_HIGH: begin
            rd_data[7:0] = s_q.snap[TEC_CNT_LINE][15:8];
         end
         TEC_IDX_LINE_LOW: begin
            rd_data[7:0] = s_q.snap[TEC_CNT_LINE][7:0];
         end
         TEC_IDX_PATH_HIGH: begin
            rd_data[7:0] = s_q.snap[TEC_CNT_PATH][15:8];
         end
         TEC_IDX_PATH_LOW: begin
            rd_data[7:0] = s_q.snap[TEC_CNT_PATH][7:0];
         end
         TEC_IDX_SYNC_HIGH: begin
            rd_data[7:0] = s_q.snap[TEC_CNT_SYNC][15:8];
         end
         TEC_IDX_SYNC_LOW: begin
            rd_data[7:0] = s_q.snap[TEC_CNT_SYNC][7:0];
         end
         default: rd_resp = TEC_RESP_SLVERR;
      endcase
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      logic e1;
      logic esf;
      logic subst;
      logic mark;
      logic bpv;
      logic bpv_counted;
      logic cv;
      logic exz;
      logic [4:0] zero_limit;
      logic [15:0] target;
      logic auto_hit;
      logic manual_edge;
      logic [TEC_CFG_W-1:0] c;

      mark = 1'b0;
      bpv = 1'b0;
      bpv_counted = 1'b0;
      cv = 1'b0;
      exz = 1'b0;
      zero_limit = TEC_ZEROS_PLAIN;
      target = SECOND_FRAMES;
      auto_hit = 1'b0;
      manual_edge = 1'b0;
      evt = '0;
      update_now = 1'b0;
      s_d = s_q;
      c = s_q.cfg;
      e1 = s_q.mode[TEC_MODE_E1];
      esf = s_q.mode[TEC_MODE_ESF];
      subst = s_q.mode[TEC_MODE_ZERO_SUBST];

      // ---------------------------------------------------------------
      // line code decode
      // ---------------------------------------------------------------
      mark = rx.bit_strobe && (rx.mark_pos != rx.mark_neg);
      bpv = mark && s_q.mark_seen && (rx.mark_pos == s_q.last_pol);
      bpv_counted = bpv && !(subst && rx.subst_code);
      cv = bpv && s_q.bpv_seen && (rx.mark_pos == s_q.last_bpv_pol);
      zero_limit = subst ? TEC_ZEROS_SUBST : TEC_ZEROS_PLAIN;
      exz = 1'b0;
      if (mark) begin
         s_d.mark_seen = 1'b1;
         s_d.last_pol = rx.mark_pos;
         s_d.zero_run = 5'h00;
      end else if (rx.bit_strobe && s_q.zero_run != zero_limit) begin
         s_d.zero_run = s_q.zero_run + 5'h01;
         exz = (s_q.zero_run + 5'h01) == zero_limit;
      end
      if (bpv) begin
         s_d.bpv_seen = 1'b1;
         s_d.last_bpv_pol = rx.mark_pos;
      end

      // ---------------------------------------------------------------
      // counted events
      // ---------------------------------------------------------------
      if (e1) begin
         evt[TEC_CNT_LINE] = c[TEC_CFG_E1_VIOL]
            ? cv : bpv_counted;
         evt[TEC_CNT_PATH] = rx.crc_error && !rx.fas_sync_lost
            && !rx.crc4_sync_lost;
         evt[TEC_CNT_SYNC] = rx.fas_error && !rx.receive_sync_lost
            && !rx.fas_search;
      end else begin
         evt[TEC_CNT_LINE] = bpv_counted
            || (c[TEC_CFG_EXCESS_ZERO] && exz);
         if (esf) begin
            evt[TEC_CNT_PATH] = rx.crc_error;
         end else begin
            evt[TEC_CNT_PATH] = rx.ft_error
               || (c[TEC_CFG_FS_REPORT] && rx.fs_error);
         end
         if (rx.receive_sync_lost) begin
            evt[TEC_CNT_PATH] = 1'b0;
         end
         if (c[TEC_CFG_SYNC_FUNC]) begin
            evt[TEC_CNT_SYNC] = rx.multiframe_start
               && rx.receive_sync_lost;
         end else begin
            evt[TEC_CNT_SYNC] = (esf ? rx.fps_error : rx.ft_error)
               && !rx.receive_sync_lost;
         end
      end

      // ---------------------------------------------------------------
      // update timing
      // ---------------------------------------------------------------
      if (c[TEC_CFG_INTERVAL]) begin
         target = e1 ? TEC_E1_SHORT_FRAMES : TEC_T1_SHORT_FRAMES;
      end else begin
         target = SECOND_FRAMES;
      end
      auto_hit = !c[TEC_CFG_ACCUM_MODE] && rx.frame_start
         && (s_q.frame_cnt >= target - 16'h0001);
      manual_edge = c[TEC_CFG_ACCUM_MODE] && c[TEC_CFG_MANUAL]
         && !s_q.manual_prev;
      s_d.manual_prev = c[TEC_CFG_MANUAL];
      update_now = auto_hit || manual_edge;
      s_d.update = update_now;
      if (update_now || c[TEC_CFG_ACCUM_MODE]) begin
         s_d.frame_cnt = 16'h0000;
      end else if (rx.frame_start) begin
         s_d.frame_cnt = s_q.frame_cnt + 16'h0001;
      end
      if (update_now) begin
         s_d.snap = cnt;
      end

      // ---------------------------------------------------------------
      // bus write
      // ---------------------------------------------------------------
      if (s_q.rsp.awready && axi_req.awvalid) begin
         s_d.rsp.awready = 1'b0;
         s_d.waddr_idx = axi_req.awaddr[TEC_ADDR_W-1:2];
      end
      if (s_q.rsp.wready && axi_req.wvalid) begin
         s_d.rsp.wready = 1'b0;
         s_d.wbyte = axi_req.wdata[7:0];
         s_d.wlane0 = axi_req.wstrb[0];
      end
      if (!s_q.rsp.awready && !s_q.rsp.wready && !s_q.rsp.bvalid) begin
         s_d.rsp.bvalid = 1'b1;
         s_d.rsp.bresp = TEC_RESP_OKAY;
         case (s_q.waddr_idx)
            TEC_IDX_COUNTER_CONFIG: begin
               if (s_q.wlane0) begin
                  s_d.cfg = s_q.wbyte[TEC_CFG_W-1:0];
               end
            end
            TEC_IDX_LINE_MODE: begin
               if (s_q.wlane0) begin
                  s_d.mode = s_q.wbyte[TEC_MODE_W-1:0];
               end
            end
            TEC_IDX_LINE_HIGH, TEC_IDX_LINE_LOW, TEC_IDX_PATH_HIGH,
            TEC_IDX_PATH_LOW, TEC_IDX_SYNC_HIGH, TEC_IDX_SYNC_LOW: begin
               s_d.rsp.bresp = TEC_RESP_OKAY;
            end
            default: s_d.rsp.bresp = TEC_RESP_SLVERR;
         endcase
      end
      if (s_q.rsp.bvalid && axi_req.bready) begin
         s_d.rsp.bvalid = 1'b0;
         s_d.rsp.awready = 1'b1;
         s_d.rsp.wready = 1'b1;
      end

      // ---------------------------------------------------------------
      // bus read
      // ---------------------------------------------------------------
      if (s_q.rsp.arready && axi_req.arvalid) begin
         s_d.rsp.arready = 1'b0;
         s_d.rsp.rvalid = 1'b1;
         s_d.rsp.rdata = rd_data;
         s_d.rsp.rresp = rd_resp;
      end
      if (s_q.rsp.rvalid && axi_req.rready) begin
         s_d.rsp.rvalid = 1'b0;
         s_d.rsp.arready = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         s_q <= '0;
         s_q.rsp.awready <= 1'b1;
         s_q.rsp.wready <= 1'b1;
         s_q.rsp.arready <= 1'b1;
         s_q.cfg <= TEC_CFG_RESET;
         s_q.mode <= TEC_MODE_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   assign axi_rsp = s_q.rsp;
   assign counts_updated = s_q.update;

endmodule // tec_error_counters

/* dv/tec_rx_model.sv */
`timescale 1ns/100ps
module tec_rx_model (
   input wire logic clock,
   output tec_pkg::tec_rx_s rx
);
   import tec_pkg::*;
   logic [14:0] p_q;
   logic [14:0] l_q;
   initial begin
      p_q = '0;
      l_q = '0;
   end
   assign rx = p_q | l_q;
   // one strobe; idle marks then show the inverse of the last bit
   task send(input logic [14:0] v);
      @(posedge clock);
      p_q <= v;
      @(posedge clock);
      p_q <= {1'b0, ~v[13:11], 11'h000};
   endtask
   task level(input logic [14:0] v);
      @(posedge clock);
      l_q <= v;
   endtask
endmodule // tec_rx_model

/* dv/tec_error_counters_properties.sv */
`timescale 1ns/100ps
module tec_error_counters_props #(
   parameter int unsigned FRAMES_PER_SECOND = 8000
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire tec_pkg::tec_axi_req_s axi_req,
   input wire tec_pkg::tec_axi_rsp_s axi_rsp,
   input wire tec_pkg::tec_rx_s rx,
   input wire logic counts_updated
);
   import tec_pkg::*;
   logic ar_bad;
   logic cfg_wr;
   logic trig_q;
   assign ar_bad = !(axi_req.araddr[8:2] inside {[7'h41:7'h47], 7'h50});
   assign cfg_wr = axi_req.awaddr[8:2] == TEC_IDX_COUNTER_CONFIG
      && axi_req.wstrb[0];
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_b);
   sequence s_wr_take;
      axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
   endsequence
   sequence s_wr_answer;
      !axi_rsp.bvalid ##1 axi_rsp.bvalid;
   endsequence
   sequence s_rd_take;
      axi_req.arvalid && axi_rsp.arready;
   endsequence
   // last trigger bit written, to spot its rising change
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         trig_q <= 1'b0;
      end else if (axi_req.awvalid && axi_rsp.awready && cfg_wr) begin
         trig_q <= axi_req.wdata[6];
      end
   end
   a_write_answer: assert property (s_wr_take |=> s_wr_answer)
      else $error("write response not two cycles after take");
   a_write_hold: assert property (axi_rsp.bvalid && !axi_req.bready
      |=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
      else $error("write response dropped early");
   a_read_answer: assert property (s_rd_take |=> axi_rsp.rvalid ##0
      !axi_rsp.arready) else $error("read answer not next cycle");
   a_read_hold: assert property (axi_rsp.rvalid && !axi_req.rready
      |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
      else $error("read data changed before taken");
   a_read_upper: assert property (axi_rsp.rvalid
      |-> axi_rsp.rdata[31:8] == 24'h000000)
      else $error("upper read bits not zero");
   a_unmapped_err: assert property (s_rd_take ##0 ar_bad
      |=> axi_rsp.rresp == TEC_RESP_SLVERR && axi_rsp.rdata == 32'h0)
      else $error("unmapped read not refused");
   a_update_pulse: assert property (counts_updated
      |=> !counts_updated) else $error("update pulse too long");
   a_manual_latch: assert property (s_wr_take ##0 cfg_wr
      && axi_req.wdata[6] && axi_req.wdata[4] && !trig_q
      |-> ##3 counts_updated) else $error("manual update missed");
endmodule // tec_error_counters_props

bind tec_error_counters tec_error_counters_props #(
   .FRAMES_PER_SECOND(FRAMES_PER_SECOND)
) chk_u (
   .clock(clock),
   .rst_b(rst_b),
   .axi_req(axi_req),
   .axi_rsp(axi_rsp),
   .rx(rx),
   .counts_updated(counts_updated)
);

/* dv/tec_error_counters_tb_top.sv */
`timescale 1ns/100ps
module tec_error_counters_tb_top;
   import tec_pkg::*;
   localparam int unsigned FPS_T = 10;
   localparam logic [14:0] P = 15'h6000, N = 15'h5000, Z = 15'h4000;
   localparam logic [14:0] S = 15'h0800, FR = 15'h0400, MF = 15'h0200;
   localparam logic [14:0] CRC = 15'h0100, FT = 15'h0080, FS = 15'h0040;
   localparam logic [14:0] FPE = 15'h0020, FAS = 15'h0010, RSL = 15'h0008;
   localparam logic [14:0] FSL = 15'h0004, C4 = 15'h0002, SRC = 15'h0001;
   localparam logic [6:0] LH = TEC_IDX_LINE_HIGH, PH = TEC_IDX_PATH_HIGH;
   localparam logic [6:0] SH = TEC_IDX_SYNC_HIGH, MD = TEC_IDX_LINE_MODE;
   logic clock;
   logic rst_b;
   tec_axi_req_s rq;
   tec_axi_rsp_s rs;
   tec_rx_s rx;
   logic counts_updated;
   logic [1:0] resp;
   logic [15:0] v;
   logic [3:0] strb;
   int fails, check_count, cyc, upd;
   tec_error_counters #(.FRAMES_PER_SECOND(FPS_T)) dut_u (.clock(clock),
      .rst_b(rst_b), .axi_req(rq), .axi_rsp(rs), .rx(rx),
      .counts_updated(counts_updated));
   tec_rx_model pm (.clock(clock), .rx(rx));
   always #10 clock = ~clock;
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (counts_updated === 1'b1) upd <= upd + 1;
      if (cyc == 30000) begin
         fails++;
         results();
      end
   end
   task results();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task chk(input string nm, input logic [15:0] s, input logic [15:0] e);
      check_count++;
      if (s !== e) begin
         fails++;
         $display("BAD %s expected %h seen %h", nm, e, s);
      end
   endtask
   task wr(input logic [6:0] i, input logic [7:0] d);
      @(posedge clock);
      rq.awvalid <= 1'b1;
      rq.awaddr <= {i, 2'h0};
      rq.wvalid <= 1'b1;
      rq.wdata <= {24'h000000, d};
      rq.wstrb <= strb;
      rq.bready <= 1'b1;
      while (rs.bvalid !== 1'b1) begin
         @(posedge clock);
         if (rs.awready === 1'b1) rq.awvalid <= 1'b0;
         if (rs.wready === 1'b1) rq.wvalid <= 1'b0;
      end
      resp = rs.bresp;
      rq.bready <= 1'b0;
   endtask
   task rd(input logic [6:0] i, output logic [7:0] d);
      @(posedge clock);
      rq.arvalid <= 1'b1;
      rq.araddr <= {i, 2'h0};
      rq.rready <= 1'b1;
      while (rs.rvalid !== 1'b1) begin
         @(posedge clock);
         if (rs.arready === 1'b1) rq.arvalid <= 1'b0;
      end
      d = rs.rdata[7:0];
      resp = rs.rresp;
      rq.rready <= 1'b0;
   endtask
   task rd16(input logic [6:0] i);
      logic [7:0] h;
      logic [7:0] l;
      rd(i, h);
      rd(i + 7'h01, l);
      v = {h, l};
   endtask
   task latch(input logic [7:0] c);
      wr(TEC_IDX_COUNTER_CONFIG, c | 8'h10);
      wr(TEC_IDX_COUNTER_CONFIG, c | 8'h50);
      repeat (3) @(posedge clock); // settle before reading
   endtask
   task ev(input logic [14:0] e, input int n);
      repeat (n) pm.send(e);
   endtask
   task t_reset();
      logic [7:0] b;
      for (int i = 0; i < 6; i++) begin
         rd(LH + 7'(i), b);
         chk("reset", {8'h00, b}, 16'h0000);
      end
      wr(TEC_IDX_LINE_LOW, 8'h5A);
      chk("ro_write", {14'h0000, resp}, {14'h0000, TEC_RESP_OKAY});
      rd(TEC_IDX_LINE_LOW, b);
      chk("read_only", {8'h00, b}, 16'h0000);
      rd(7'h10, b);
      chk("unmapped", {14'h0000, resp}, {14'h0000, TEC_RESP_SLVERR});
      wr(7'h10, 8'h00);
      chk("unmapped_wr", {14'h0000, resp}, {14'h0000, TEC_RESP_SLVERR});
      strb = 4'hE;
      wr(TEC_IDX_COUNTER_CONFIG, 8'h7F);
      strb = 4'hF;
      rd(TEC_IDX_COUNTER_CONFIG, b);
      chk("cfg_lane", {8'h00, b}, 16'h0000);
   endtask
   task t_t1_line();
      wr(MD, 8'h00);
      pm.level(RSL);
      pm.send(N);
      latch(8'h01);
      ev(P, 2);
      ev(Z, 16);
      latch(8'h01);
      rd16(LH);
      chk("t1_line", v, 16'h0002);
      ev(P, 1);
      rd16(LH);
      chk("t1_hold", v, 16'h0002);
      wr(MD, 8'h04);
      latch(8'h01);
      ev(N, 1);
      ev(N | S, 1);
      ev(Z, 8);
      latch(8'h01);
      rd16(LH);
      chk("t1_subst", v, 16'h0001);
   endtask
   task t_e1_line();
      wr(MD, 8'h05);
      pm.level(RSL | FSL | C4);
      latch(8'h00);
      ev(P, 2);
      ev(N, 1);
      ev(N | S, 1);
      latch(8'h08); // code violations with HDB3 decoding
      rd16(LH);
      chk("e1_bpv", v, 16'h0001);
      ev(N, 1);
      ev(P, 2);
      latch(8'h08);
      rd16(LH);
      chk("e1_cv", v, 16'h0001);
      pm.level(15'h0000);
   endtask
   task t_path();
      wr(MD, 8'h00);
      latch(8'h00);
      ev(FT, 1);
      ev(FS, 1);
      pm.level(RSL);
      ev(FT, 1);
      pm.level(15'h0000);
      latch(8'h04);
      rd16(PH);
      chk("d4_ft", v, 16'h0001);
      ev(FT, 1);
      ev(FS, 1);
      wr(MD, 8'h02);
      ev(CRC, 1);
      ev(FS, 1);
      latch(8'h00);
      rd16(PH);
      chk("fs_crc6", v, 16'h0003);
      wr(MD, 8'h01);
      ev(CRC, 1);
      pm.level(FSL);
      ev(CRC, 1);
      pm.level(C4);
      ev(CRC, 1);
      pm.level(15'h0000);
      latch(8'h00);
      rd16(PH);
      chk("e1_crc4", v, 16'h0001);
   endtask
   task t_sync();
      wr(MD, 8'h00);
      ev(FT, 1);
      pm.level(RSL);
      ev(FT, 1);
      pm.level(15'h0000);
      wr(MD, 8'h02);
      ev(FPE, 1);
      latch(8'h02);
      rd16(SH);
      chk("fbit", v, 16'h0002);
      pm.level(RSL);
      ev(MF, 1);
      pm.level(15'h0000);
      ev(MF, 1);
      latch(8'h00);
      rd16(SH);
      chk("multiframe", v, 16'h0001);
      wr(MD, 8'h01);
      ev(FAS, 1);
      pm.level(RSL);
      ev(FAS, 1);
      pm.level(SRC);
      ev(FAS, 1);
      pm.level(15'h0000);
      latch(8'h00);
      rd16(SH);
      chk("e1_fas", v, 16'h0001);
   endtask
   task t_interval();
      int tgt;
      int n0;
      latch(8'h00);
      ev(CRC, 1);
      for (int k = 0; k < 3; k++) begin
         tgt = (k == 0) ? FPS_T : (k == 1) ? 333 : 500;
         wr(MD, (k == 1) ? 8'h00 : 8'h01);
         wr(TEC_IDX_COUNTER_CONFIG, (k == 0) ? 8'h00 : 8'h20);
         n0 = upd;
         ev(FR, tgt - 1);
         repeat (2) @(posedge clock);
         chk("early", 16'(upd - n0), 16'h0000);
         ev(FR, 1);
         repeat (2) @(posedge clock);
         chk("on_time", 16'(upd - n0), 16'h0001);
         rd16(PH);
         chk("auto_path", v, (k == 0) ? 16'h0001 : 16'h0000);
      end
   endtask
   initial begin
      clock = 1'b0;
      rst_b = 1'b0;
      rq = '0;
      strb = 4'hF;
      repeat (2) @(posedge clock);
      rst_b <= 1'b1;
      t_reset();
      t_t1_line();
      t_e1_line();
      t_path();
      t_sync();
      t_interval();
      results();
   end
endmodule // tec_error_counters_tb_top
